// ### inc/standstill_consts.svh
// Constants of the standstill and overspeed monitor.
// Assumes a 20 MHz core clock; included by the package and the design.
`ifndef STANDSTILL_CONSTS_SVH
`define STANDSTILL_CONSTS_SVH

// ----------------------------------------
// Clock and measuring gate
// ----------------------------------------
`define CLK_HZ 20000000
`define US_PER_S 1000000
`define GATE_TIME_US 10000

// ----------------------------------------
// Unit conversion factors
// ----------------------------------------
`define SEC_PER_MIN 60
`define MILLI 1000
`define PERCENT 100

// ----------------------------------------
// Widths and limits
// ----------------------------------------
`define CNT_W 16
`define SPEED_W 16
`define RES_W 16
`define GEAR_W 8
`define HYST_W 7
`define THR_CNT_W 4
`define SEL_W 3
`define SC_W 12
`define CALC_W 64
`define THR_MAX 8
`define THR_MAX_REDUCED 4

// ----------------------------------------
// Plausibility limits and reset values
// ----------------------------------------
`define SINCOS_SQ_MIN 25'h0040000
`define SINCOS_SQ_MAX 25'h0190000
`define SINCOS_ABS_MIN 14'h0200
`define PLAUS_TOL_SHIFT 3
`define FLAG_RST 1'b0

`endif

// ### inc/standstill_pkg.sv
// Types of the standstill and overspeed monitor.
// Assumes the constants header is on the include path.
`include "standstill_consts.svh"

package standstill_pkg;

    // ----------------------------------------
    // Configuration encodings
    // ----------------------------------------
    typedef enum logic {AXIS_ROT = 1'b0, AXIS_LIN = 1'b1} axis_t;
    typedef enum logic {SENSOR_ROT = 1'b0, SENSOR_LIN = 1'b1} sensor_kind_t;

    typedef enum logic [2:0] {
        DEV_ENC = 3'h0,
        DEV_PROX = 3'h1,
        DEV_ENC_PROX = 3'h2,
        DEV_PROX_PROX = 3'h3,
        DEV_ENC_ENC = 3'h4
    } meas_dev_t;

    typedef enum logic [3:0] {
        PROX_NONE = 4'h0,
        PROX_PNP3_NC = 4'h1,
        PROX_PNP3_NO = 4'h2,
        PROX_NPN3_NO = 4'h3,
        PROX_NPN3_NC = 4'h4,
        PROX_PNP4_NCNO = 4'h5,
        PROX_NPN4_NCNO = 4'h6,
        PROX_4_NCNC = 4'h7,
        PROX_4_NONO = 4'h8
    } prox_kind_t;

    typedef enum logic [1:0] {
        DIR_BIDIR = 2'h0,
        DIR_CW = 2'h1,
        DIR_CCW = 2'h2
    } dir_mode_t;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic a;
        logic b;
    } pin_pair_t;

    typedef struct packed {
        logic signed [`SC_W-1:0] sine;
        logic signed [`SC_W-1:0] cosine;
    } sincos_t;

    typedef logic [`THR_MAX-1:0][`SPEED_W-1:0] thr_table_t;

    typedef struct packed {
        axis_t axis;
        sensor_kind_t sensor;
        meas_dev_t device;
        prox_kind_t prox_kind;
        logic sincos_present;
        logic analog_check_off;
        logic dir_enable;
        dir_mode_t dir_mode;
        logic [`THR_CNT_W-1:0] thr_count;
        logic [`HYST_W-1:0] hyst_pct;
        logic [`RES_W-1:0] pitch;
        logic [`RES_W-1:0] meas_res;
        logic [`RES_W-1:0] verif_res;
        logic [`GEAR_W-1:0] gear;
        logic [`SPEED_W-1:0] zero_limit;
    } cfg_t;

endpackage

// ### src/pulse_rate_counter.sv
// Gated pulse counter with quadrature direction for one speed sensor.
// Assumes pin inputs synchronous to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "standstill_consts.svh"

module pulse_rate_counter #(
    parameter int GATE_CYCLES = 200000
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire standstill_pkg::pin_pair_t pins_i,
    output logic [`CNT_W-1:0] count_o,
    output logic ccw_o,
    output logic done_o,
    output logic valid_o
);
    localparam int GW = $clog2(GATE_CYCLES);

    logic [GW-1:0] gate;
    logic [`CNT_W-1:0] acc;
    logic a_prev;

    wire rise = pins_i.a & ~a_prev;
    wire gate_end = (gate == GW'(GATE_CYCLES - 1));
    // Saturate rather than wrap, a wrap would look like standstill
    wire [`CNT_W-1:0] acc_inc = acc + {{(`CNT_W-1){1'b0}}, rise & ~(&acc)};
    wire [GW-1:0] next_gate = gate_end ? '0 : GW'(gate + 1'b1);
    wire [`CNT_W-1:0] next_acc = gate_end ? '0 : acc_inc;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gate <= '0;
            acc <= '0;
            a_prev <= 1'b0;
            count_o <= '0;
            ccw_o <= 1'b0;
            done_o <= 1'b0;
            valid_o <= 1'b0;
        end else begin
            gate <= next_gate;
            acc <= next_acc;
            a_prev <= pins_i.a;
            done_o <= gate_end;
            if (gate_end) begin
                count_o <= acc_inc;
                valid_o <= 1'b1;
            end
            // B high at the rising edge of A means counterclockwise
            if (rise) begin
                ccw_o <= pins_i.b;
            end
        end
    end

endmodule
`default_nettype wire

// ### src/standstill_overspeed_monitor.sv
// Standstill and overspeed monitor for one machine axis.
// Assumes sensor pins and configuration synchronous to core_clk_i and
// configuration held steady while the axis is monitored.
`timescale 1ns/1ps
`default_nettype none
`include "standstill_consts.svh"

module standstill_overspeed_monitor #(
    parameter int GATE_CYCLES = `GATE_TIME_US * (`CLK_HZ / `US_PER_S)
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire standstill_pkg::cfg_t cfg_i,
    input wire standstill_pkg::thr_table_t thr_speed_i,
    input wire logic reduced_variant_i,
    input wire logic thr_select_bit0_i,
    input wire logic thr_select_bit1_i,
    input wire logic thr_select_bit2_i,
    input wire standstill_pkg::pin_pair_t enc1_i,
    input wire standstill_pkg::pin_pair_t enc2_i,
    input wire standstill_pkg::pin_pair_t prox1_i,
    input wire standstill_pkg::pin_pair_t prox2_i,
    input wire standstill_pkg::sincos_t sincos_i,
    output logic standstill_o,
    output logic under_thr_o,
    output logic dir_o,
    output logic dir_offered_o,
    output logic thr_select_used_o,
    output logic meas_valid_o,
    output logic error_o
);
    // Gates per second; a shortened gate raises it accordingly
    localparam int GPS = `CLK_HZ / GATE_CYCLES;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Returns {fault, target present} for one proximity switch
    function automatic logic [1:0] prox_decode(
        input standstill_pkg::prox_kind_t kind,
        input standstill_pkg::pin_pair_t p
    );
        logic present;
        logic fault;
        present = 1'b0;
        fault = 1'b0;
        unique case (kind)
            standstill_pkg::PROX_NONE: begin
                fault = 1'b1;
            end
            standstill_pkg::PROX_PNP3_NC: begin
                present = ~p.a;
            end
            standstill_pkg::PROX_PNP3_NO: begin
                present = p.a;
            end
            standstill_pkg::PROX_NPN3_NO: begin
                present = ~p.a;
            end
            standstill_pkg::PROX_NPN3_NC: begin
                present = p.a;
            end
            standstill_pkg::PROX_PNP4_NCNO: begin
                present = p.a;
                fault = (p.a == p.b);
            end
            standstill_pkg::PROX_NPN4_NCNO: begin
                present = ~p.a;
                fault = (p.a == p.b);
            end
            standstill_pkg::PROX_4_NCNC: begin
                present = ~p.a;
                fault = (p.a != p.b);
            end
            standstill_pkg::PROX_4_NONO: begin
                present = p.a;
                fault = (p.a != p.b);
            end
            default: begin
                fault = 1'b1;
            end
        endcase
        return {fault, present};
    endfunction

    // Below-limit flag with hysteresis between release and trip point
    function automatic logic below_hyst(
        input logic cur,
        input logic [`CALC_W-1:0] meas,
        input logic [`CALC_W-1:0] trip,
        input logic [`CALC_W-1:0] rel
    );
        logic res;
        res = cur;
        if (meas > trip) begin
            res = 1'b0;
        end else if (meas < rel) begin
            res = 1'b1;
        end
        return res;
    endfunction

    // ----------------------------------------
    // Sensor configuration decode
    // ----------------------------------------
    standstill_pkg::meas_dev_t dev;
    assign dev = cfg_i.device;

    wire has_enc = (dev == standstill_pkg::DEV_ENC) ||
        (dev == standstill_pkg::DEV_ENC_PROX) ||
        (dev == standstill_pkg::DEV_ENC_ENC);
    wire two_sensors = (dev == standstill_pkg::DEV_ENC_PROX) ||
        (dev == standstill_pkg::DEV_PROX_PROX) ||
        (dev == standstill_pkg::DEV_ENC_ENC);
    wire prox1_used = (dev == standstill_pkg::DEV_PROX) ||
        (dev == standstill_pkg::DEV_ENC_PROX) ||
        (dev == standstill_pkg::DEV_PROX_PROX);
    wire prox2_used = (dev == standstill_pkg::DEV_PROX_PROX);
    wire dev_illegal = (dev > standstill_pkg::DEV_ENC_ENC);

    // ----------------------------------------
    // Proximity decode and sensor routing
    // ----------------------------------------
    wire [1:0] prox1_dec = prox_decode(cfg_i.prox_kind, prox1_i);
    wire [1:0] prox2_dec = prox_decode(cfg_i.prox_kind, prox2_i);
    wire prox_fault = (prox1_used & prox1_dec[1]) |
        (prox2_used & prox2_dec[1]);

    standstill_pkg::pin_pair_t prox1_n;
    standstill_pkg::pin_pair_t prox2_n;
    standstill_pkg::pin_pair_t s1_pins;
    standstill_pkg::pin_pair_t s2_pins;
    assign prox1_n = '{a: prox1_dec[0], b: 1'b0};
    assign prox2_n = '{a: prox2_dec[0], b: 1'b0};

    // First sensor is the encoder whenever one is present
    assign s1_pins = has_enc ? enc1_i : prox1_n;
    assign s2_pins = (dev == standstill_pkg::DEV_ENC_PROX) ? prox1_n :
        (dev == standstill_pkg::DEV_PROX_PROX) ? prox2_n :
        (dev == standstill_pkg::DEV_ENC_ENC) ? enc2_i :
        standstill_pkg::pin_pair_t'(2'b00);

    // ----------------------------------------
    // Pulse counters
    // ----------------------------------------
    // Both counters leave reset together, so their gates stay aligned
    logic [`CNT_W-1:0] cnt1;
    logic [`CNT_W-1:0] cnt2;
    logic ccw1;
    logic s1_done;
    logic s1_valid;

    pulse_rate_counter #(.GATE_CYCLES(GATE_CYCLES)) u_sensor1 (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .pins_i(s1_pins),
        .count_o(cnt1),
        .ccw_o(ccw1),
        .done_o(s1_done),
        .valid_o(s1_valid)
    );

    pulse_rate_counter #(.GATE_CYCLES(GATE_CYCLES)) u_sensor2 (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .pins_i(s2_pins),
        .count_o(cnt2),
        .ccw_o(),
        .done_o(),
        .valid_o()
    );

    // ----------------------------------------
    // Sine/cosine plausibility
    // ----------------------------------------
    wire signed [`SC_W:0] sine_ext = (`SC_W+1)'(sincos_i.sine);
    wire signed [`SC_W:0] cos_ext = (`SC_W+1)'(sincos_i.cosine);
    wire [`SC_W:0] abs_sine = sine_ext[`SC_W] ? (`SC_W+1)'(-sine_ext) :
        (`SC_W+1)'(sine_ext);
    wire [`SC_W:0] abs_cos = cos_ext[`SC_W] ? (`SC_W+1)'(-cos_ext) :
        (`SC_W+1)'(cos_ext);
    wire [2*`SC_W-1:0] sine_sq = (2*`SC_W)'(abs_sine * abs_sine);
    wire [2*`SC_W-1:0] cos_sq = (2*`SC_W)'(abs_cos * abs_cos);
    wire [2*`SC_W:0] sq_sum = (2*`SC_W+1)'(sine_sq) +
        (2*`SC_W+1)'(cos_sq);
    wire [`SC_W+1:0] abs_sum = (`SC_W+2)'(abs_sine) + (`SC_W+2)'(abs_cos);
    wire analog_bad = (sq_sum < `SINCOS_SQ_MIN) || (sq_sum > `SINCOS_SQ_MAX);
    wire simple_bad = (abs_sum < `SINCOS_ABS_MIN);
    wire sincos_fault = cfg_i.sincos_present & has_enc &
        (cfg_i.analog_check_off ? simple_bad : analog_bad);

    // ----------------------------------------
    // Threshold selection
    // ----------------------------------------
    wire [`THR_CNT_W-1:0] thr_cap = reduced_variant_i ?
        `THR_CNT_W'(`THR_MAX_REDUCED) : `THR_CNT_W'(`THR_MAX);
    wire [`THR_CNT_W-1:0] thr_eff = (cfg_i.thr_count == '0) ?
        `THR_CNT_W'(1) :
        (cfg_i.thr_count > thr_cap) ? thr_cap : cfg_i.thr_count;
    wire [`SEL_W-1:0] sel_raw = {thr_select_bit2_i, thr_select_bit1_i,
        thr_select_bit0_i};
    wire [`SEL_W-1:0] sel_mask = (thr_eff > `THR_CNT_W'(4)) ? 3'h7 :
        (thr_eff > `THR_CNT_W'(2)) ? 3'h3 :
        (thr_eff > `THR_CNT_W'(1)) ? 3'h1 : 3'h0;
    wire [`SEL_W-1:0] sel_masked = sel_raw & sel_mask;
    // An index past the configured count falls back to the last threshold
    wire [`SEL_W-1:0] sel_idx = (`THR_CNT_W'(sel_masked) >= thr_eff) ?
        `SEL_W'(thr_eff - 1'b1) : sel_masked;
    wire [`SPEED_W-1:0] sel_speed = thr_speed_i[sel_idx];

    // ----------------------------------------
    // Unit scaling
    // ----------------------------------------
    // Both sides of each comparison carry the common denominator, so no
    // divider is needed: meas * lscale against speed * rscale.
    wire axis_lin = (cfg_i.axis == standstill_pkg::AXIS_LIN);
    wire sensor_lin = axis_lin &
        (cfg_i.sensor == standstill_pkg::SENSOR_LIN);

    wire [31:0] lscale = !axis_lin ? 32'(`SEC_PER_MIN) :
        !sensor_lin ? 32'(`SEC_PER_MIN) * 32'(cfg_i.pitch) :
        32'(cfg_i.meas_res);
    wire [31:0] rscale = !axis_lin ? 32'(cfg_i.meas_res) :
        !sensor_lin ? 32'(`MILLI) * 32'(cfg_i.meas_res) :
        32'(`MILLI);

    wire [`HYST_W-1:0] hyst_eff = (cfg_i.hyst_pct > `HYST_W'(`PERCENT)) ?
        `HYST_W'(`PERCENT) : cfg_i.hyst_pct;
    wire [`HYST_W-1:0] rel_pct = `HYST_W'(`PERCENT) - hyst_eff;

    wire [`CALC_W-1:0] meas_scaled = `CALC_W'(cnt1) * `CALC_W'(GPS) *
        `CALC_W'(lscale) * `CALC_W'(`PERCENT);
    wire [`CALC_W-1:0] zero_base = `CALC_W'(cfg_i.zero_limit) *
        `CALC_W'(rscale);
    wire [`CALC_W-1:0] thr_base = `CALC_W'(sel_speed) * `CALC_W'(rscale);
    wire [`CALC_W-1:0] zero_trip = zero_base * `CALC_W'(`PERCENT);
    wire [`CALC_W-1:0] zero_release = zero_base * `CALC_W'(rel_pct);
    wire [`CALC_W-1:0] trip_frequency = thr_base * `CALC_W'(`PERCENT);
    wire [`CALC_W-1:0] release_frequency =
        thr_base * `CALC_W'(rel_pct);

    // ----------------------------------------
    // Redundant sensor cross-check
    // ----------------------------------------
    wire [`CALC_W-1:0] plaus_l = `CALC_W'(cnt2) * `CALC_W'(cfg_i.meas_res);
    wire [`CALC_W-1:0] plaus_r = `CALC_W'(cfg_i.gear) * `CALC_W'(cnt1) *
        `CALC_W'(cfg_i.verif_res);
    wire [`CALC_W-1:0] plaus_diff = (plaus_l > plaus_r) ?
        plaus_l - plaus_r : plaus_r - plaus_l;
    // Allow one count of quantisation on each sensor plus a relative band
    wire [`CALC_W-1:0] plaus_tol = ((plaus_l + plaus_r) >> `PLAUS_TOL_SHIFT) +
        `CALC_W'(cfg_i.meas_res) +
        `CALC_W'(cfg_i.gear) * `CALC_W'(cfg_i.verif_res);
    wire mismatch = two_sensors & (plaus_diff > plaus_tol);

    // ----------------------------------------
    // Flag state
    // ----------------------------------------
    logic zero_state;
    logic under_state;
    logic valid;
    logic err;

    wire next_zero = below_hyst(zero_state, meas_scaled, zero_trip,
        zero_release);
    wire next_under = below_hyst(under_state, meas_scaled, trip_frequency,
        release_frequency);
    // Error latches until reset; a safety trip must not clear by itself
    wire next_err = err | prox_fault | sincos_fault | dev_illegal |
        (s1_done & mismatch);
    wire flags_ok = valid & ~err;

    // Direction qualification of the overspeed check
    wire dir_qual = !has_enc ||
        (cfg_i.dir_mode == standstill_pkg::DIR_BIDIR) ||
        ((cfg_i.dir_mode == standstill_pkg::DIR_CW) && !ccw1) ||
        ((cfg_i.dir_mode == standstill_pkg::DIR_CCW) && ccw1);
    wire next_standstill = flags_ok & zero_state;
    wire next_under_out = flags_ok & (under_state | ~dir_qual);
    wire next_dir_offered = cfg_i.dir_enable & has_enc;
    wire next_dir = next_dir_offered & ccw1;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            zero_state <= `FLAG_RST;
            under_state <= `FLAG_RST;
            valid <= 1'b0;
            err <= 1'b0;
        end else begin
            err <= next_err;
            if (s1_done) begin
                zero_state <= next_zero;
                under_state <= next_under;
                valid <= s1_valid;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            standstill_o <= `FLAG_RST;
            under_thr_o <= `FLAG_RST;
            dir_o <= 1'b0;
            dir_offered_o <= 1'b0;
            thr_select_used_o <= 1'b0;
            meas_valid_o <= 1'b0;
        end else begin
            standstill_o <= next_standstill;
            under_thr_o <= next_under_out;
            dir_o <= next_dir;
            dir_offered_o <= next_dir_offered;
            thr_select_used_o <= (thr_eff > `THR_CNT_W'(1));
            meas_valid_o <= valid;
        end
    end

    assign error_o = err;

endmodule
`default_nettype wire

// ### verif/sensor_axis_model.sv
// Quadrature encoder and proximity pulses of one turning axis.
// Assumes the bench changes period and direction at clock edges.
`timescale 1ns/1ps
`default_nettype none

module sensor_axis_model (
    input wire logic core_clk_i,
    input wire logic [7:0] period_i,
    input wire logic ccw_i,
    input wire logic second_on_i,
    output var standstill_pkg::pin_pair_t enc1_o,
    output var standstill_pkg::pin_pair_t enc2_o,
    output var standstill_pkg::pin_pair_t prox1_o,
    output var standstill_pkg::pin_pair_t prox2_o
);
    logic [7:0] ph;
    logic a;
    logic b;

    // Period zero stops the shaft, lines freeze
    always_ff @(posedge core_clk_i) begin
        if (period_i == 8'h00 || ph >= period_i - 8'h01) begin
            ph <= 8'h00;
        end else begin
            ph <= ph + 8'h01;
        end
    end

    assign a = ph < (period_i >> 1);
    // Second line high at a rise when turning counterclockwise
    assign b = ccw_i ^ (ph >= (period_i >> 2) &&
        ph < (period_i >> 2) + (period_i >> 1));
    assign enc1_o = {a, b};
    assign enc2_o = second_on_i ? {a, b} : 2'h0;
    assign prox1_o = {a, ~a};
    assign prox2_o = second_on_i ? {a, ~a} : 2'h0;
endmodule

`default_nettype wire

// ### verif/standstill_props.sv
// Port checker of the standstill and overspeed monitor.
// Assumes it is bound onto the monitor's top module.
`timescale 1ns/1ps
`default_nettype none

module standstill_props #(
    parameter int GATE_CYCLES = 200
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire standstill_pkg::cfg_t cfg_i,
    input wire logic standstill_o,
    input wire logic under_thr_o,
    input wire logic dir_offered_o,
    input wire logic thr_select_used_o,
    input wire logic meas_valid_o,
    input wire logic error_o
);
    int cyc;

    // Cycles since reset release, saturating
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cyc <= 0;
        end else if (cyc < GATE_CYCLES + 8) begin
            cyc <= cyc + 1;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_flags_low;
        !standstill_o && !under_thr_o;
    endsequence

    a_reset_flags_low:
        assert property ($fell(reset_i) |-> s_flags_low)
        else $error("flags high at reset release");
    a_valid_not_early:
        assert property (cyc < GATE_CYCLES - 2 |-> !meas_valid_o)
        else $error("measurement valid before first gate");
    a_valid_after_gate:
        assert property (cyc == GATE_CYCLES + 4 |-> meas_valid_o)
        else $error("measurement not valid after first gate");
    a_invalid_flags_low:
        assert property (!meas_valid_o |-> s_flags_low)
        else $error("flag high without measurement");
    a_error_kills_flags:
        assert property (error_o |-> ##3 s_flags_low)
        else $error("flag high during fault");
    a_error_stays:
        assert property (error_o |=> error_o)
        else $error("fault indication dropped");
    a_under_holds:
        assert property ($rose(under_thr_o) |=> (under_thr_o || error_o)[*8])
        else $error("threshold flag changed between gates");
    a_stand_holds:
        assert property ($fell(standstill_o) |=> (!standstill_o)[*8])
        else $error("standstill flag changed between gates");
    a_dir_needs_enc:
        assert property (dir_offered_o && $stable(cfg_i) |-> cfg_i.dir_enable
            && cfg_i.device != standstill_pkg::DEV_PROX
            && cfg_i.device != standstill_pkg::DEV_PROX_PROX)
        else $error("direction offered without encoder");
    a_select_used:
        assert property ($stable(cfg_i) && !$past(reset_i) |->
            thr_select_used_o == (cfg_i.thr_count > 4'h1))
        else $error("select use flag wrong");
endmodule

bind standstill_overspeed_monitor standstill_props #(
    .GATE_CYCLES(GATE_CYCLES)
) u_props (.core_clk_i, .reset_i, .cfg_i, .standstill_o, .under_thr_o,
    .dir_offered_o, .thr_select_used_o, .meas_valid_o, .error_o);

`default_nettype wire

// ### verif/test_standstill_overspeed_monitor.sv
// Self-checking bench of the standstill and overspeed monitor.
// Assumes the sensor model drives every pin pair.
`timescale 1ns/1ps
`default_nettype none

module test_standstill_overspeed_monitor;
    localparam int GATE = 200;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic red = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [7:0] per = 8'h00;
    logic ccw = 1'b0;
    logic second = 1'b1;
    standstill_pkg::cfg_t cfg;
    standstill_pkg::thr_table_t thr;
    standstill_pkg::sincos_t sc = '0;
    standstill_pkg::pin_pair_t e1, e2, p1, p2;
    logic stand, under, dir, offered, used, valid, err;
    int error_cnt = 0;
    int total_checks = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    sensor_axis_model u_axis (.core_clk_i(clk), .period_i(per), .ccw_i(ccw),
        .second_on_i(second), .enc1_o(e1), .enc2_o(e2), .prox1_o(p1),
        .prox2_o(p2));

    standstill_overspeed_monitor #(.GATE_CYCLES(GATE)) u_dut (
        .core_clk_i(clk), .reset_i(rst), .cfg_i(cfg), .thr_speed_i(thr),
        .reduced_variant_i(red), .thr_select_bit0_i(sel[0]),
        .thr_select_bit1_i(sel[1]), .thr_select_bit2_i(sel[2]),
        .enc1_i(e1), .enc2_i(e2), .prox1_i(p1), .prox2_i(p2),
        .sincos_i(sc), .standstill_o(stand), .under_thr_o(under),
        .dir_o(dir), .dir_offered_o(offered), .thr_select_used_o(used),
        .meas_valid_o(valid), .error_o(err));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic gates(input int n);
        repeat (n * GATE) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic spin(input logic [7:0] p, input logic c);
        @(posedge clk);
        per <= p;
        ccw <= c;
        gates(3);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios, speed in rpm is 100 per pulse a gate
    // ----------------------------------------
    task automatic t_reset();
        do_reset();
        check("standstill", stand, 1'b0);
        check("under", under, 1'b0);
        check("valid", valid, 1'b0);
        spin(8'h00, 1'b0);
        check("standstill", stand, 1'b1);
        spin(8'h14, 1'b0);
        check("standstill", stand, 1'b0);
    endtask

    task automatic t_select();
        check("select used", used, 1'b1);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            sel <= k[2:0];
            gates(2);
            check("under select", under, k[0]);
        end
        @(posedge clk);
        red <= 1'b1;
        sel <= 3'h4;
        gates(2);
        check("under capped", under, 1'b0);
        @(posedge clk);
        red <= 1'b0;
        cfg.thr_count <= 4'h3;
        sel <= 3'h3;
        gates(2);
        check("under clamped", under, 1'b0);
        @(posedge clk);
        red <= 1'b0;
        cfg.thr_count <= 4'h1;
        sel <= 3'h1;
        gates(2);
        check("select used", used, 1'b0);
        check("under single", under, 1'b0);
    endtask

    task automatic t_hyst();
        logic [7:0] ps [5] = '{8'h28, 8'h10, 8'h16, 8'h28, 8'h16};
        logic [4:0] ex = 5'h19;
        @(posedge clk);
        cfg.thr_count <= 4'h8;
        sel <= 3'h0;
        cfg.hyst_pct <= 7'h14;
        thr <= {8{16'h03E8}};
        for (int i = 0; i < 5; i++) begin
            spin(ps[i], 1'b0);
            check("under hyst", under, ex[i]);
        end
    endtask

    task automatic t_dir();
        logic [1:0] md [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
        logic [4:0] cc = 5'h13;
        logic [4:0] ux = 5'h0A;
        @(posedge clk);
        cfg.hyst_pct <= 7'h00;
        thr <= {8{16'h01F4}};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            cfg.dir_mode <= standstill_pkg::dir_mode_t'(md[i]);
            spin(8'h14, cc[i]);
            check("offered", offered, 1'b1);
            check("direction", dir, cc[i]);
            check("under mode", under, ux[i]);
        end
        @(posedge clk);
        cfg.dir_mode <= standstill_pkg::DIR_BIDIR;
        cfg.device <= standstill_pkg::DEV_PROX;
        cfg.prox_kind <= standstill_pkg::PROX_PNP3_NO;
        do_reset();
        spin(8'h14, 1'b1);
        check("offered prox", offered, 1'b0);
        check("under prox", under, 1'b0);
        check("error prox", err, 1'b0);
    endtask

    task automatic t_error();
        @(posedge clk);
        cfg.device <= standstill_pkg::DEV_ENC_ENC;
        cfg.prox_kind <= standstill_pkg::PROX_NONE;
        thr <= {8{16'h07D0}};
        do_reset();
        spin(8'h14, 1'b0);
        check("error agree", err, 1'b0);
        check("under agree", under, 1'b1);
        @(posedge clk);
        second <= 1'b0;
        gates(3);
        check("error", err, 1'b1);
        check("under fault", under, 1'b0);
    endtask

    task automatic t_sincos();
        @(posedge clk);
        cfg.device <= standstill_pkg::DEV_ENC;
        cfg.sincos_present <= 1'b1;
        cfg.analog_check_off <= 1'b1;
        sc <= {12'h180, 12'h0C0};
        do_reset();
        check("sincos simple", err, 1'b0);
        @(posedge clk);
        cfg.analog_check_off <= 1'b0;
        gates(1);
        check("sincos analog", err, 1'b1);
    endtask

    initial begin
        cfg = '0;
        cfg.dir_enable = 1'b1;
        cfg.thr_count = 4'h8;
        cfg.pitch = 16'h0001;
        cfg.meas_res = 16'hEA60;
        cfg.verif_res = 16'hEA60;
        cfg.gear = 8'h01;
        cfg.zero_limit = 16'h0032;
        for (int i = 0; i < 8; i++) begin
            thr[i] = i[0] ? 16'h07D0 : 16'h01F4;
        end
        t_reset();
        t_select();
        t_hyst();
        t_dir();
        t_error();
        t_sincos();
        end_of_test();
    end
endmodule

`default_nettype wire
